// ===== pcfl_regs.svh
`ifndef PCFL_REGS_SVH
`define PCFL_REGS_SVH

// Register byte offsets on the APB window
`define PCFL_OFS_FLAGS     8'h00
`define PCFL_OFS_FALL_EN   8'h04
`define PCFL_OFS_RISE_EN   8'h08
`define PCFL_OFS_CTRL      8'h0C
`define PCFL_OFS_EVT_STAT  8'h10
`define PCFL_OFS_EVT_MASK  8'h14

// Number of port pins watched
`define PCFL_PIN_CNT       6

// Control register field positions
`define PCFL_CTRL_MEN_BIT  0
`define PCFL_CTRL_SUM_BIT  1

// Reset values
`define PCFL_FLAGS_RST     6'h00
`define PCFL_EN_RST        6'h00
`define PCFL_EVT_RST       6'h00
`define PCFL_MEN_RST       1'b0
`define PCFL_WORD_RST      32'h0000_0000

`endif

// ===== pcfl_pkg.sv
package pcfl_pkg;

  // One bit per watched pin
  typedef logic [5:0] pcfl_pins_type;

  // APB slave answer sequencing
  typedef enum logic {
    PCFL_BUS_IDLE,
    PCFL_BUS_ANSWER
  } pcfl_bus_state_type;

endpackage

// ===== pcfl_edge_if.sv
`timescale 1ns/10ps
`default_nettype none

// Edge pulses from the pin front end to the flag logic
interface pcfl_edge_if;
  import pcfl_pkg::*;

  pcfl_pins_type rise;   // One-cycle low-to-high pulse per pin
  pcfl_pins_type fall;   // One-cycle high-to-low pulse per pin

  // Producer side
  modport src (
    output rise,
    output fall
  );

  // Consumer side
  modport dst (
    input  rise,
    input  fall
  );
endinterface

`default_nettype wire

// ===== pcfl_edge_detect.sv
`include "pcfl_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module pcfl_edge_detect
  import pcfl_pkg::*;
(
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Asynchronous pins
  input  wire pcfl_pins_type port_a_pin,
  // Edge pulses out
  pcfl_edge_if.src           edge_o
);

  pcfl_pins_type meta_reg;   // First synchroniser stage
  pcfl_pins_type sync_reg;   // Second synchroniser stage
  pcfl_pins_type prev_reg;   // Previous synchronised sample

  genvar g;
  generate
    for (g = 0; g < `PCFL_PIN_CNT; g++) begin : g_pin
      // [R11] two-stage sync, history
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_reg[g] <= 1'b0;
          sync_reg[g] <= 1'b0;
          prev_reg[g] <= 1'b0;
        end else begin
          meta_reg[g] <= port_a_pin[g];
          sync_reg[g] <= meta_reg[g];
          prev_reg[g] <= sync_reg[g];
        end
      end
    end
  endgenerate

  // [R11] compare current with previous
  assign edge_o.rise = sync_reg & ~prev_reg;
  assign edge_o.fall = ~sync_reg & prev_reg;

  // Edge pulse lasts exactly one cycle
  property p_rise_one_cycle;
    @(posedge pclk) disable iff (!presetn)
      (|edge_o.rise) |=> ((edge_o.rise & $past(edge_o.rise)) == 6'h00);
  endproperty
  a_rise_one_cycle: assert property (p_rise_one_cycle) // [R11]
    else $error("rise pulse held more than one cycle");

  // A pin change reaches the rise output two edges later
  property p_pin_to_rise;
    @(posedge pclk) disable iff (!presetn)
      ($rose(port_a_pin[0]) ##1 port_a_pin[0] [*2]) |-> edge_o.rise[0];
  endproperty
  a_pin_to_rise: assert property (p_pin_to_rise) // [R11]
    else $error("pin rise not seen after sync delay");

endmodule

`default_nettype wire

// ===== pcfl_top.sv
// Overview of operation
// [R1] Enabled rising edge sets pin flag
// [R2] Enabled falling edge sets pin flag
// [R3] Six flags, set only by enabled edges; a software write of one also sets a flag
// [R4] Flag bits above five read zero
// [R5] Writing zero clears flag until edge
// [R6] Flags writable, hardware settable, reset zero
// [R7] Summary flag is OR of flags
// [R8] Interrupt only with master enable set
// [R9] Edge during clear keeps flag set
// [R10] Enabled change wakes; flags ready first
// [R11] Pins synchronised, edges by sample compare
`include "pcfl_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module pcfl_top
  import pcfl_pkg::*;
(
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // APB slave
  input  wire logic [7:0]    paddr,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Port pins
  input  wire pcfl_pins_type port_a_pin,
  // Interrupt and wake
  output logic               irq,
  output logic               wake_req
);

  // Bus state and answer flip-flops
  pcfl_bus_state_type bus_state_reg;   // Slave sequencing state
  logic [31:0]        prdata_reg;      // Captured read word
  logic               pready_reg;      // Answer strobe
  logic               pslverr_reg;     // Unmapped address answer

  // Software visible state
  pcfl_pins_type      flag_reg;        // Per-pin change flags
  pcfl_pins_type      flag_next;       // Next flag value
  pcfl_pins_type      fall_en_reg;     // Falling edge enables
  pcfl_pins_type      rise_en_reg;     // Rising edge enables
  logic               men_reg;         // Master interrupt enable
  pcfl_pins_type      evt_reg;         // Sticky event status
  pcfl_pins_type      evt_next;        // Next event status
  pcfl_pins_type      evt_mask_reg;    // Event interrupt mask
  logic               irq_reg;         // Interrupt output flop
  logic               wake_reg;        // Wake request flop

  // Decode and helpers
  pcfl_pins_type      edge_hit;        // Enabled edges this cycle
  pcfl_pins_type      wdata_pins;      // Write data pin field
  logic               summary;         // OR of all flags
  logic               addr_hit;        // Address is mapped
  logic [31:0]        read_word;       // Word for current address
  logic               setup_cyc;       // APB setup phase seen
  logic               wr_fire;         // Write completes this edge
  logic               wr_flags;        // Write to flag register
  logic               wr_evt;          // Write to event status

  // Edge pulses from the pin front end
  pcfl_edge_if edge_bus ();

  // Pin synchroniser and edge detector
  pcfl_edge_detect u_edge (
    .pclk       (pclk),
    .presetn    (presetn),
    .port_a_pin (port_a_pin),
    .edge_o     (edge_bus.src)
  );

  // Output ports straight from flops
  assign prdata   = prdata_reg;
  assign pready   = pready_reg;
  assign pslverr  = pslverr_reg;
  assign irq      = irq_reg;
  assign wake_req = wake_reg;

  // [R1] [R2] edge qualified by enable
  assign edge_hit   = (edge_bus.rise & rise_en_reg) | (edge_bus.fall & fall_en_reg);
  assign wdata_pins = pwdata[5:0];

  // [R7] summary is OR of flags
  assign summary = |flag_reg;

  // Transfer phase decode
  assign setup_cyc = (bus_state_reg == PCFL_BUS_IDLE) && psel && !penable;
  assign wr_fire   = (bus_state_reg == PCFL_BUS_ANSWER) && psel && penable
                     && pwrite && !pslverr_reg;
  assign wr_flags  = wr_fire && (paddr == `PCFL_OFS_FLAGS);
  assign wr_evt    = wr_fire && (paddr == `PCFL_OFS_EVT_STAT);

  // Read mux and address decode
  always_comb begin
    read_word = `PCFL_WORD_RST;
    addr_hit  = 1'b1;
    case (paddr)
      // [R4] upper flag bits read zero
      `PCFL_OFS_FLAGS: begin
        read_word[5:0] = flag_reg;
      end
      `PCFL_OFS_FALL_EN: begin
        read_word[5:0] = fall_en_reg;
      end
      `PCFL_OFS_RISE_EN: begin
        read_word[5:0] = rise_en_reg;
      end
      `PCFL_OFS_CTRL: begin
        read_word[`PCFL_CTRL_MEN_BIT] = men_reg;
        read_word[`PCFL_CTRL_SUM_BIT] = summary;
      end
      `PCFL_OFS_EVT_STAT: begin
        read_word[5:0] = evt_reg;
      end
      `PCFL_OFS_EVT_MASK: begin
        read_word[5:0] = evt_mask_reg;
      end
      // Unmapped: zero data, error answer
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // APB answer: one wait-free access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_state_reg <= PCFL_BUS_IDLE;
      prdata_reg    <= `PCFL_WORD_RST;
      pready_reg    <= 1'b0;
      pslverr_reg   <= 1'b0;
    end else begin
      case (bus_state_reg)
        // Capture read data in the setup cycle
        PCFL_BUS_IDLE: begin
          if (setup_cyc) begin
            bus_state_reg <= PCFL_BUS_ANSWER;
            pready_reg    <= 1'b1;
            pslverr_reg   <= !addr_hit;
            prdata_reg    <= pwrite ? `PCFL_WORD_RST : read_word;
          end
        end
        // Access completes at this edge
        PCFL_BUS_ANSWER: begin
          if (psel && penable) begin
            bus_state_reg <= PCFL_BUS_IDLE;
            pready_reg    <= 1'b0;
            pslverr_reg   <= 1'b0;
          end
        end
        // Recover to idle
        default: begin
          bus_state_reg <= PCFL_BUS_IDLE;
          pready_reg    <= 1'b0;
          pslverr_reg   <= 1'b0;
        end
      endcase
    end
  end

  // Next flag value
  always_comb begin
    flag_next = flag_reg;
    // [R5] software write, zero clears
    if (wr_flags) begin
      flag_next = wdata_pins;
    end
    // [R9] edge wins over clear
    flag_next = flag_next | edge_hit;
  end

  // [R6] flags reset to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= `PCFL_FLAGS_RST;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // [R3] enables steer which edges count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fall_en_reg <= `PCFL_EN_RST;
      rise_en_reg <= `PCFL_EN_RST;
    end else if (wr_fire) begin
      if (paddr == `PCFL_OFS_FALL_EN) begin
        fall_en_reg <= wdata_pins;
      end
      if (paddr == `PCFL_OFS_RISE_EN) begin
        rise_en_reg <= wdata_pins;
      end
    end
  end

  // Master enable and event mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      men_reg      <= `PCFL_MEN_RST;
      evt_mask_reg <= `PCFL_EVT_RST;
    end else if (wr_fire) begin
      if (paddr == `PCFL_OFS_CTRL) begin
        men_reg <= pwdata[`PCFL_CTRL_MEN_BIT];
      end
      if (paddr == `PCFL_OFS_EVT_MASK) begin
        evt_mask_reg <= wdata_pins;
      end
    end
  end

  // Sticky events, write one to clear, set wins
  always_comb begin
    evt_next = evt_reg;
    if (wr_evt) begin
      evt_next = evt_reg & ~wdata_pins;
    end
    evt_next = evt_next | edge_hit;
  end

  // Event status flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_reg <= `PCFL_EVT_RST;
    end else begin
      evt_reg <= evt_next;
    end
  end

  // [R8] interrupt gated by master enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= men_reg && (|(evt_reg & evt_mask_reg));
    end
  end

  // [R10] wake with flags already updated
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= men_reg && (|flag_next);
    end
  end

  // Setup of a read of the flag register
  sequence s_flags_read;
    setup_cyc && !pwrite && (paddr == `PCFL_OFS_FLAGS);
  endsequence

  // Setup of a read of the control register
  sequence s_ctrl_read;
    setup_cyc && !pwrite && (paddr == `PCFL_OFS_CTRL);
  endsequence

  // Flag write completing together with an edge
  sequence s_clear_with_edge;
    wr_flags && (|edge_hit);
  endsequence

  property p_rise_sets;
    @(posedge pclk) disable iff (!presetn)
      (|(edge_bus.rise & rise_en_reg))
        |=> ((flag_reg & $past(edge_hit)) == $past(edge_hit));
  endproperty
  a_rise_sets: assert property (p_rise_sets) // [R1]
    else $error("enabled rising edge did not set flag");

  property p_fall_sets;
    @(posedge pclk) disable iff (!presetn)
      (|(edge_bus.fall & fall_en_reg)) |=> ((flag_reg & $past(edge_hit)) != 6'h00);
  endproperty
  a_fall_sets: assert property (p_fall_sets) // [R2]
    else $error("enabled falling edge did not set flag");

  property p_no_stray_set;
    @(posedge pclk) disable iff (!presetn)
      !wr_flags |=> ((flag_reg & ~$past(flag_reg) & ~$past(edge_hit)) == 6'h00);
  endproperty
  a_no_stray_set: assert property (p_no_stray_set) // [R3]
    else $error("flag set without an enabled edge");

  property p_upper_zero;
    @(posedge pclk) disable iff (!presetn)
      s_flags_read |=> (prdata_reg[31:6] == 26'h000_0000) ##1 !pready_reg;
  endproperty
  a_upper_zero: assert property (p_upper_zero) // [R4]
    else $error("flag read returned nonzero upper bits");

  property p_write_clears;
    @(posedge pclk) disable iff (!presetn)
      wr_flags |=> (flag_reg == ($past(wdata_pins) | $past(edge_hit)));
  endproperty
  a_write_clears: assert property (p_write_clears) // [R5]
    else $error("flag write did not take effect");

  property p_summary_read;
    @(posedge pclk) disable iff (!presetn)
      s_ctrl_read |=> (prdata_reg[`PCFL_CTRL_SUM_BIT] == $past(summary)) && pready_reg;
  endproperty
  a_summary_read: assert property (p_summary_read) // [R7]
    else $error("summary flag not OR of flags");

  property p_irq_gated;
    @(posedge pclk) disable iff (!presetn)
      !men_reg [*2] |-> !irq_reg;
  endproperty
  a_irq_gated: assert property (p_irq_gated) // [R8]
    else $error("interrupt raised with master enable clear");

  property p_edge_beats_clear;
    @(posedge pclk) disable iff (!presetn)
      s_clear_with_edge |=> ((flag_reg & $past(edge_hit)) == $past(edge_hit));
  endproperty
  a_edge_beats_clear: assert property (p_edge_beats_clear) // [R9]
    else $error("edge lost during flag clear");

  property p_wake_follows;
    @(posedge pclk) disable iff (!presetn)
      $past(men_reg) && (|flag_reg) |-> wake_reg;
  endproperty
  a_wake_follows: assert property (p_wake_follows) // [R10]
    else $error("wake missing with flags set and enabled");

  // Detection keeps running with master enable clear
  property p_detect_without_men;
    @(posedge pclk) disable iff (!presetn)
      !men_reg && (|edge_hit) |=> ((flag_reg & $past(edge_hit)) == $past(edge_hit));
  endproperty
  a_detect_without_men: assert property (p_detect_without_men) // [R8]
    else $error("flag not set while master enable clear");

  // No wake request while master enable is clear
  property p_wake_needs_men;
    @(posedge pclk) disable iff (!presetn)
      !men_reg |=> !wake_reg;
  endproperty
  a_wake_needs_men: assert property (p_wake_needs_men) // [R10]
    else $error("wake raised with master enable clear");

endmodule

`default_nettype wire

// ===== pcfl_pin_model.sv
`timescale 1ns/10ps
`default_nettype none

// Outside world driving the six port pins
module pcfl_pin_model
  import pcfl_pkg::*;
(
  // Clock
  input  wire logic          pclk,
  // Level requested by the bench
  input  wire pcfl_pins_type level_req,
  // Pins toward the block
  output var pcfl_pins_type  port_a_pin
);
  // Pins move a cycle after the request, unrelated to any bus access
  always_ff @(posedge pclk) begin
    port_a_pin <= level_req;
  end
endmodule

`default_nettype wire

// ===== pcfl_top_tb.sv
`include "pcfl_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module pcfl_top_tb
  import pcfl_pkg::*;
;
  logic          pclk    = 1'b0;    // Bus clock
  logic          presetn = 1'b0;    // Reset, active low
  logic [7:0]    paddr   = 8'h00;   // Bus address
  logic          psel    = 1'b0;    // Select
  logic          penable = 1'b0;    // Access phase
  logic          pwrite  = 1'b0;    // Direction
  logic [31:0]   pwdata  = 32'h0000_0000;
  logic [31:0]   prdata;            // Read data
  logic          pready;            // Answer
  logic          pslverr;           // Error
  pcfl_pins_type pins;              // Pin wires
  pcfl_pins_type lvl     = 6'h00;   // Requested pin levels
  logic          irq;               // Interrupt
  logic          wake_req;          // Wake
  int            n_errors = 0;      // Mismatches
  int            n_tests  = 0;      // Comparisons
  logic [31:0]   rd;                // Last read word
  logic          er;                // Last error bit
  pcfl_pins_type flg, evt, ren, fen, msk; // Expected state

  // Clock at 40 MHz
  always #12.5 pclk = ~pclk;

  pcfl_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_a_pin(pins), .irq(irq),
    .wake_req(wake_req));

  pcfl_pin_model pm (.pclk(pclk), .level_req(lvl), .port_a_pin(pins));

  // Flags an edge pattern sets
  function automatic pcfl_pins_type edges(pcfl_pins_type o, pcfl_pins_type n,
                                          pcfl_pins_type r, pcfl_pins_type f);
    return (r & ~o & n) | (f & o & ~n);
  endfunction

  // Verdict and end of run
  task automatic finish_test;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Word comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read and compare flags, control word, irq and wake
  task automatic check_all(input logic men);
    apb(1'b0, `PCFL_OFS_FLAGS, 0);
    chk(rd, {26'h0, flg});
    apb(1'b0, `PCFL_OFS_CTRL, 0);
    chk(rd, {30'h0, |flg, men});
    chk({31'h0, er}, 32'h0000_0000);
    chk({30'h0, irq, wake_req}, {30'h0, men & |(evt & msk), men & |flg});
  endtask

  // Pin step with model update
  task automatic step(input pcfl_pins_type n);
    flg = flg | edges(lvl, n, ren, fen);
    evt = evt | edges(lvl, n, ren, fen);
    lvl <= n;
    repeat (6) @(posedge pclk);
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    finish_test();
  end

  // Main sequence
  initial begin
    void'($urandom(84));
    flg = 0;
    evt = 0;
    msk = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and unmapped word
    for (int a = 0; a <= 8'h18; a += 4) begin
      apb(1'b0, 8'(a), 0);
      chk(rd, 32'h0000_0000);
      chk({31'h0, er}, {31'h0, a == 8'h18});
    end
    // Random enables and pin traffic
    for (int t = 0; t < 4; t++) begin
      ren = 6'($urandom);
      fen = (t == 0) ? 6'h00 : 6'($urandom);
      apb(1'b1, `PCFL_OFS_RISE_EN, {26'h0, ren});
      apb(1'b1, `PCFL_OFS_FALL_EN, {26'h0, fen});
      msk = (t == 0) ? 6'h3F : 6'($urandom);
      apb(1'b1, `PCFL_OFS_EVT_MASK, {26'h0, msk});
      apb(1'b1, `PCFL_OFS_CTRL, {31'h0, t != 3});
      for (int i = 0; i < 8; i++) begin
        step(6'($urandom));
        check_all(t != 3);
      end
      // Software write stores value, zero clears
      flg = 6'($urandom);
      apb(1'b1, `PCFL_OFS_FLAGS, {26'($urandom), flg});
      check_all(t != 3);
      apb(1'b1, `PCFL_OFS_EVT_STAT, 32'h0000_003F);
      evt = 0;
    end
    // Reset in mid-run clears flags, enables and mask
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    flg = 0;
    evt = 0;
    ren = 0;
    fen = 0;
    msk = 0;
    check_all(1'b0);
    // Edge arriving during a clearing write keeps the flag
    ren = 6'h3F;
    apb(1'b1, `PCFL_OFS_RISE_EN, {26'h0, ren});
    lvl <= 6'h00;
    repeat (6) @(posedge pclk);
    apb(1'b1, `PCFL_OFS_FLAGS, 0);
    lvl <= 6'h01;
    @(posedge pclk);
    apb(1'b1, `PCFL_OFS_FLAGS, 0);
    apb(1'b0, `PCFL_OFS_FLAGS, 0);
    chk(rd, 32'h0000_0001);
    finish_test();
  end
endmodule

`default_nettype wire
